// ---- stx_pkg.sv ----
// constants and types shared by the 8b/10b serial transmitter
// assumes one clock that runs at the serial bit rate
package stx_pkg;
   // ----------------------------------------------------------------
   // symbol timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned BITS_PER_SYM = 10;
   localparam logic [3:0] CNT_LAST = 4'h9;
   localparam logic [3:0] CNT_RESET = 4'h0;
   // read strobe is low while the bit counter is below this value
   localparam logic [3:0] STROBE_LOW_END = 4'h5;

   // ----------------------------------------------------------------
   // symbols and field layout
   // ----------------------------------------------------------------
   localparam logic [7:0] COMMA_BYTE = 8'hbc;
   localparam logic [4:0] K28_LOW = 5'h1c;
   localparam int unsigned LOW_LSB = 0;
   localparam int unsigned HIGH_LSB = 5;
   // violation symbol for negative disparity, complemented for positive
   localparam logic [9:0] VIOL_SYM_NEG = 10'h278;
   localparam logic [9:0] SYM_RESET = 10'h000;
   localparam logic RD_RESET = 1'b0;

   // ----------------------------------------------------------------
   // self-test generator
   // ----------------------------------------------------------------
   localparam logic [8:0] LFSR_SEED = 9'h1ff;
   localparam int unsigned LFSR_TAP = 4;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   typedef struct packed {
      logic [7:0] data;
      logic ctrl;
      logic viol;
      logic comma;
   } stx_word_t;
endpackage

// ---- stx_sym_if.sv ----
// carries one held input word to the encoder and the code back
// assumes both ends sit in the same clock domain
`timescale 1ns/1ns
interface stx_sym_if;
   import stx_pkg::*;
   stx_word_t word;
   logic bypass;
   logic rd_in;
   logic [9:0] sym;
   logic rd_out;

   modport enc (input word, input bypass, input rd_in, output sym, output rd_out);
   modport core (output word, output bypass, output rd_in, input sym, input rd_out);
endinterface

// ---- stx_enc.sv ----
// combinational 8b/10b encoder with bypass and violation insert
// assumes the caller holds running disparity between symbols
`timescale 1ns/1ns
module stx_enc
   import stx_pkg::*;
(
   stx_sym_if.enc sym_if
);
   // ----------------------------------------------------------------
   // code tables, negative disparity form, bit a in the msb
   // ----------------------------------------------------------------
   function automatic logic [5:0] tab6(input logic [4:0] x);
      logic [5:0] t;
      t = 6'h00;
      unique case (x)
         5'd0: t = 6'b100111; 5'd1: t = 6'b011101; 5'd2: t = 6'b101101; 5'd3: t = 6'b110001;
         5'd4: t = 6'b110101; 5'd5: t = 6'b101001; 5'd6: t = 6'b011001; 5'd7: t = 6'b111000;
         5'd8: t = 6'b111001; 5'd9: t = 6'b100101; 5'd10: t = 6'b010101; 5'd11: t = 6'b110100;
         5'd12: t = 6'b001101; 5'd13: t = 6'b101100; 5'd14: t = 6'b011100; 5'd15: t = 6'b010111;
         5'd16: t = 6'b011011; 5'd17: t = 6'b100011; 5'd18: t = 6'b010011; 5'd19: t = 6'b110010;
         5'd20: t = 6'b001011; 5'd21: t = 6'b101010; 5'd22: t = 6'b011010; 5'd23: t = 6'b111010;
         5'd24: t = 6'b110011; 5'd25: t = 6'b100110; 5'd26: t = 6'b010110; 5'd27: t = 6'b110110;
         5'd28: t = 6'b001110; 5'd29: t = 6'b101110; 5'd30: t = 6'b011110; 5'd31: t = 6'b101011;
      endcase
      return t;
   endfunction

   function automatic logic [3:0] tab4(input logic [2:0] y);
      logic [3:0] t;
      t = 4'h0;
      unique case (y)
         3'd0: t = 4'b1011; 3'd1: t = 4'b1001; 3'd2: t = 4'b0101; 3'd3: t = 4'b1100;
         3'd4: t = 4'b1101; 3'd5: t = 4'b1010; 3'd6: t = 4'b0110; 3'd7: t = 4'b1110;
      endcase
      return t;
   endfunction

   function automatic logic balanced(input logic [5:0] v, input logic [2:0] half);
      logic [2:0] n;
      n = 3'd0;
      for (int i = 0; i < 6; i++) begin
         n = n + {2'b00, v[i]};
      end
      return n == half;
   endfunction

   // ----------------------------------------------------------------
   // encoding
   // ----------------------------------------------------------------
   logic [4:0] x;
   logic [2:0] y;
   logic k28;
   logic [5:0] c6;
   logic [3:0] c4;
   logic bal6;
   logic bal4;
   logic rd_mid;
   logic alt7;

   always_comb begin
      x = sym_if.word.data[LOW_LSB +: 5];
      y = sym_if.word.data[HIGH_LSB +: 3];
      k28 = sym_if.word.ctrl && (x == K28_LOW);
      c6 = k28 ? 6'b001111 : tab6(x);
      bal6 = balanced(c6, 3'd3);
      if (sym_if.rd_in && (!bal6 || x == 5'd7)) begin
         c6 = ~c6;
      end
      rd_mid = sym_if.rd_in ^ !bal6;
      // alternate form keeps run length at five, control codes always use it
      alt7 = (y == 3'd7) && (sym_if.word.ctrl ||
             (!rd_mid && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
             (rd_mid && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
      c4 = alt7 ? 4'b0111 : tab4(y);
      bal4 = balanced({2'b00, c4}, 3'd2);
      // control x.28 flips its balanced 4b codes other than y of 3 on the opposite disparity to data codes
      if ((rd_mid && (!bal4 || y == 3'd3)) || (k28 && bal4 && y != 3'd3 && !rd_mid)) begin
         c4 = ~c4;
      end
      sym_if.sym = {c6, c4};
      sym_if.rd_out = rd_mid ^ !bal4;
      if (sym_if.word.comma) begin
         sym_if.sym = sym_if.rd_in ? 10'b1100000101 : 10'b0011111010;
         sym_if.rd_out = !sym_if.rd_in;
      end else if (sym_if.word.viol) begin
         // balanced, so disparity is left alone
         sym_if.sym = sym_if.rd_in ? ~VIOL_SYM_NEG : VIOL_SYM_NEG;
         sym_if.rd_out = sym_if.rd_in;
      end
      if (sym_if.bypass) begin
         // bit a is the qualifier, bit j the violation input
         sym_if.sym[9] = sym_if.word.ctrl;
         for (int i = 0; i < 8; i++) begin
            sym_if.sym[8 - i] = sym_if.word.data[i];
         end
         sym_if.sym[0] = sym_if.word.viol;
         sym_if.rd_out = sym_if.rd_in;
      end
   end
endmodule

// ---- stx_top.sv ----
// 8b/10b serial transmitter: input register, encoder, shifter, outputs
// assumes i_clk is the bit clock; a byte time is ten clocks, counted here
//
// Contract
// - load_now_n low captures data, qualifier and violation at byte edge.
// - load_next_n low at an edge loads the inputs at the next edge.
// - no enable low at a byte edge, with no load_next_n pending, sends the comma symbol.
// - data, qualifier and violation bit are latched together as one word.
// - qualifier high uses special table, low uses data table.
// - violation bit set sends a defined violation symbol instead.
// - bypass mode sends the ten input bits raw, bit a first.
// - one 10-bit symbol per byte time, shifted at ten times byte rate.
// - shifter transfer timed by internal counter only, not pin levels.
// - same serial stream drives all three serial outputs.
// - output-off forces first two outputs low, third keeps data.
// - output-off acts within few bits, not aligned to symbols.
// - self-test turns input register into 511-state LFSR generator.
// - byte-rate read strobe from internal counter, fixed width and phase.
`timescale 1ns/1ns
module stx_top
   import stx_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_data,
   input wire logic i_ctrl_or_data_sel,
   input wire logic i_force_violation,
   input wire logic i_load_now_n,
   input wire logic i_load_next_n,
   input wire logic i_bypass_mode,
   input wire logic i_self_test_enable_n,
   input wire logic i_serial_out_off,
   output logic o_serial_out_first,
   output logic o_serial_out_second,
   output logic o_serial_out_loopback,
   output logic o_fifo_read_strobe_n,
   output logic o_byte_tick
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] cnt;
      logic [9:0] sh;
      logic rd;
      stx_word_t word;
      logic pend;
      logic [8:0] lfsr;
      logic out_first;
      logic out_second;
      logic out_loop;
      logic strobe_n;
      logic tick;
   } stx_state_t;

   stx_state_t cur_ff;
   stx_state_t nxt_st;
   logic byte_edge;
   logic take;

   stx_sym_if sym_if ();

   assign sym_if.word = cur_ff.word;
   assign sym_if.bypass = i_bypass_mode;
   assign sym_if.rd_in = cur_ff.rd;

   stx_enc u_enc (
      .sym_if(sym_if)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = cur_ff;
      // byte edge comes from the counter alone
      byte_edge = (cur_ff.cnt == CNT_LAST);
      take = !i_load_now_n || cur_ff.pend;
      nxt_st.cnt = byte_edge ? CNT_RESET : cur_ff.cnt + 4'h1;
      nxt_st.sh = {cur_ff.sh[8:0], 1'b0};
      if (byte_edge) begin
         // held word goes out in the byte after it was taken
         nxt_st.sh = sym_if.sym;
         nxt_st.rd = sym_if.rd_out;
         nxt_st.pend = !i_load_next_n;
         if (!i_self_test_enable_n) begin
            // maximal length x^9 + x^5 + 1, so 511 states
            nxt_st.lfsr = {cur_ff.lfsr[7:0], cur_ff.lfsr[8] ^ cur_ff.lfsr[LFSR_TAP]};
            nxt_st.word.data = cur_ff.lfsr[7:0];
            nxt_st.word.ctrl = cur_ff.lfsr[8];
            nxt_st.word.viol = cur_ff.lfsr[8] && (cur_ff.lfsr[7:0] == BYTE_RESET);
            nxt_st.word.comma = 1'b0;
         end else if (take) begin
            nxt_st.lfsr = LFSR_SEED;
            nxt_st.word.data = i_data;
            nxt_st.word.ctrl = i_ctrl_or_data_sel;
            nxt_st.word.viol = i_force_violation;
            nxt_st.word.comma = 1'b0;
         end else begin
            // keeps the far end framed while idle
            nxt_st.lfsr = LFSR_SEED;
            nxt_st.word.data = COMMA_BYTE;
            nxt_st.word.ctrl = 1'b1;
            nxt_st.word.viol = 1'b0;
            nxt_st.word.comma = 1'b1;
         end
      end
      // gating is unsynchronised to symbols on purpose
      nxt_st.out_first = cur_ff.sh[9] && !i_serial_out_off;
      nxt_st.out_second = cur_ff.sh[9] && !i_serial_out_off;
      nxt_st.out_loop = cur_ff.sh[9];
      // width set by the counter, never by input timing
      // falls only at a byte edge, so the first pulse after reset is never cut short
      if (byte_edge) begin
         nxt_st.strobe_n = 1'b0;
      end else if (nxt_st.cnt == STROBE_LOW_END) begin
         nxt_st.strobe_n = 1'b1;
      end else begin
         nxt_st.strobe_n = cur_ff.strobe_n;
      end
      nxt_st.tick = byte_edge;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cur_ff <= '{cnt: CNT_RESET, sh: SYM_RESET, rd: RD_RESET,
                     word: '{data: COMMA_BYTE, ctrl: 1'b1, viol: 1'b0, comma: 1'b1},
                     pend: 1'b0, lfsr: LFSR_SEED, out_first: 1'b0, out_second: 1'b0,
                     out_loop: 1'b0, strobe_n: 1'b1, tick: 1'b0};
      end else begin
         cur_ff <= nxt_st;
      end
   end

   assign o_serial_out_first = cur_ff.out_first;
   assign o_serial_out_second = cur_ff.out_second;
   assign o_serial_out_loopback = cur_ff.out_loop;
   assign o_fifo_read_strobe_n = cur_ff.strobe_n;
   assign o_byte_tick = cur_ff.tick;
endmodule

// ---- stx_host_model.sv ----
// host side model: presents one whole input word or stays idle
// assumes the caller steps it just after a falling clock edge
`timescale 1ns/1ns
module stx_host_model (
   output logic [7:0] o_data,
   output logic o_ctrl,
   output logic o_viol,
   output logic o_load_now_n,
   output logic o_load_next_n
);
   // word and enables change together, never bit by bit
   task put(input logic [7:0] d, input logic c, input logic v, input logic now_n, input logic nxt_n);
      o_data = d;
      o_ctrl = c;
      o_viol = v;
      o_load_now_n = now_n;
      o_load_next_n = nxt_n;
   endtask
   // idle data is inverted so a stale word is never mistaken for a load
   task idle();
      put(~o_data, 1'b0, 1'b0, 1'b1, 1'b1);
   endtask
   initial begin
      put(8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
   end
endmodule

// ---- stx_top_props.sv ----
// port-level timing checks for the serial transmitter
// assumes it is bound to stx_top; i_clk is the bit clock
`timescale 1ns/1ns
module stx_top_props (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_serial_out_off,
   input wire logic o_serial_out_first,
   input wire logic o_serial_out_second,
   input wire logic o_serial_out_loopback,
   input wire logic o_fifo_read_strobe_n,
   input wire logic o_byte_tick
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   a_first_follows_loop: assert property (
      !$past(i_serial_out_off) |-> o_serial_out_first == o_serial_out_loopback)
      else $error("first output differs from loopback");
   a_off_kills_first: assert property (
      $past(i_serial_out_off) |-> !o_serial_out_first && !o_serial_out_second)
      else $error("gated output not forced low");
   a_pair_identical: assert property (
      o_serial_out_first == o_serial_out_second)
      else $error("first and second outputs differ");
   a_tick_period: assert property (
      o_byte_tick |-> ##10 o_byte_tick)
      else $error("byte tick not ten clocks apart");
   a_tick_single: assert property (
      o_byte_tick |=> !o_byte_tick [*8] ##1 !o_byte_tick)
      else $error("extra byte tick inside a byte time");
   a_strobe_low_five: assert property (
      $fell(o_fifo_read_strobe_n) |=> !o_fifo_read_strobe_n [*4] ##1 o_fifo_read_strobe_n [*5])
      else $error("read strobe width wrong");
   a_strobe_on_tick: assert property (
      o_byte_tick |-> $fell(o_fifo_read_strobe_n))
      else $error("read strobe not aligned to byte tick");
   a_rise_then_tick: assert property (
      $rose(o_fifo_read_strobe_n) |-> ##5 o_byte_tick)
      else $error("read strobe phase wrong");
endmodule
bind stx_top stx_top_props stx_top_props_inst (.i_clk(i_clk), .i_reset(i_reset),
   .i_serial_out_off(i_serial_out_off), .o_serial_out_first(o_serial_out_first),
   .o_serial_out_second(o_serial_out_second), .o_serial_out_loopback(o_serial_out_loopback),
   .o_fifo_read_strobe_n(o_fifo_read_strobe_n), .o_byte_tick(o_byte_tick));

// ---- tb_stx_top.sv ----
// self-checking bench for the serial transmitter
// assumes the host model owns the word inputs; the bench owns modes
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("unexpected %0t: %h", $time, a); end end
module tb_stx_top;
   import stx_pkg::*;
   localparam logic [9:0] COMMA_NEG = 10'h0fa;
   localparam logic [9:0] D0_NEG = 10'h274;
   localparam logic [9:0] D28_5 = 10'h0ea;
   logic i_clk, i_reset, i_bypass_mode, i_self_test_enable_n, i_serial_out_off;
   logic [7:0] w_data;
   logic w_ctrl, w_viol, w_now_n, w_next_n, first, second, loop, strobe_n, tick;
   int error_cnt, checks_done;
   stx_host_model host_inst (.o_data(w_data), .o_ctrl(w_ctrl), .o_viol(w_viol),
      .o_load_now_n(w_now_n), .o_load_next_n(w_next_n));
   stx_top stx_top_inst (.i_clk(i_clk), .i_reset(i_reset), .i_data(w_data), .i_ctrl_or_data_sel(w_ctrl),
      .i_force_violation(w_viol), .i_load_now_n(w_now_n), .i_load_next_n(w_next_n),
      .i_bypass_mode(i_bypass_mode), .i_self_test_enable_n(i_self_test_enable_n),
      .i_serial_out_off(i_serial_out_off), .o_serial_out_first(first), .o_serial_out_second(second),
      .o_serial_out_loopback(loop), .o_fifo_read_strobe_n(strobe_n), .o_byte_tick(tick));
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   function automatic logic in_pair(input logic [9:0] s, input logic [9:0] p);
      return (s === p) || (s === ~p);
   endfunction
   task automatic wait_tick();
      int n;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (tick !== 1'b1 && n < 20);
      `CHK(tick, 1'b1)
   endtask
   // bit a leads, so it lands in the top bit
   task automatic grab(input bit wait_first, output logic [9:0] s);
      s = 10'h000;
      if (wait_first) wait_tick();
      for (int i = 0; i < 10; i++) begin
         @(negedge i_clk);
         s = {s[8:0], loop};
      end
   endtask
   task automatic send(input logic [7:0] d, input logic c, v, byp, nxt, output logic [9:0] s);
      wait_tick();
      if (nxt) begin
         host_inst.put(d, c, v, 1'b1, 1'b0);
         wait_tick();
         host_inst.put(d, c, v, 1'b1, 1'b1);
      end else
         host_inst.put(d, c, v, 1'b0, 1'b1);
      i_bypass_mode = byp;
      wait_tick();
      host_inst.idle();
      wait_tick();
      i_bypass_mode = 1'b0;
      grab(1'b0, s);
   endtask
   task automatic t_idle();
      logic [9:0] s1, s2;
      grab(1'b1, s1);
      grab(1'b0, s2);
      `CHK(strobe_n, 1'b0)
      `CHK(in_pair(s1, COMMA_NEG), 1'b1)
      `CHK(s2, ~s1)
   endtask
   task automatic t_tables();
      logic [9:0] s;
      send(8'hbc, 1'b0, 1'b0, 1'b0, 1'b0, s);
      `CHK(s, D28_5)
      send(8'hbc, 1'b1, 1'b0, 1'b0, 1'b0, s);
      `CHK(in_pair(s, COMMA_NEG), 1'b1)
      send(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, s);
      `CHK(in_pair(s, D0_NEG), 1'b1)
      send(8'h00, 1'b0, 1'b1, 1'b0, 1'b0, s);
      `CHK(in_pair(s, VIOL_SYM_NEG), 1'b1)
      send(8'hbc, 1'b0, 1'b0, 1'b0, 1'b1, s);
      `CHK(s, D28_5)
   endtask
   task automatic t_bypass();
      logic [9:0] s, e;
      logic [7:0] d;
      for (int k = 0; k < 2; k++) begin
         d = k ? 8'h3c : 8'ha5;
         e = {k == 0, 8'h00, k == 1};
         for (int i = 0; i < 8; i++) e[8 - i] = d[i];
         send(d, k == 0, k == 1, 1'b1, 1'b0, s);
         `CHK(s, e)
      end
   endtask
   task automatic t_off();
      logic [9:0] s;
      wait_tick();
      repeat (4) @(negedge i_clk);
      i_serial_out_off = 1'b1;
      grab(1'b1, s);
      `CHK(first, 1'b0)
      `CHK(second, 1'b0)
      `CHK(in_pair(s, COMMA_NEG), 1'b1)
      i_serial_out_off = 1'b0;
      repeat (2) @(negedge i_clk);
      `CHK(first, loop)
   endtask
   task automatic t_self_test();
      logic [9:0] s;
      int odd;
      odd = 0;
      i_self_test_enable_n = 1'b0;
      repeat (6) begin
         grab(1'b1, s);
         odd += !in_pair(s, COMMA_NEG);
      end
      i_self_test_enable_n = 1'b1;
      `CHK(odd != 0, 1'b1)
   endtask
   task automatic end_of_test();
      $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      error_cnt = 0;
      checks_done = 0;
      i_reset = 1'b1;
      i_bypass_mode = 1'b0;
      i_self_test_enable_n = 1'b1;
      i_serial_out_off = 1'b0;
      repeat (6) @(negedge i_clk);
      i_reset = 1'b0;
      t_idle();
      t_tables();
      t_bypass();
      t_off();
      t_self_test();
      end_of_test();
   end
   // whole run needs well under a thousand clocks
   initial begin
      #(20 * 4000);
      error_cnt++;
      end_of_test();
   end
endmodule
